// ### design/dpsel_defs.vh
`ifndef DPSEL_DEFS_VH
`define DPSEL_DEFS_VH
// Select patterns, arrival order is MSB first
`define DPSEL_J2S_PATTERN   16'h79E7
`define DPSEL_S2J_PATTERN   16'h3CE7
`define DPSEL_PAT_BITS      16
// High run that counts as a line reset on the serial wire
`define DPSEL_LINE_RESET_MIN 50
// Highs already counted when a further high realigns the bit counter; no pattern holds more than four highs
`define DPSEL_REALIGN_RUN    6'h04
// Zero-bit scan counter limits
`define DPSEL_ZBS_MAX       3'h7
`define DPSEL_ZBS_ENTRY     3'h6
// TAP state encodings
`define DPSEL_TAP_TLR       4'h0
`define DPSEL_TAP_RTI       4'h1
`define DPSEL_TAP_SELDR     4'h2
`define DPSEL_TAP_CAPDR     4'h3
`define DPSEL_TAP_SHDR      4'h4
`define DPSEL_TAP_EX1DR     4'h5
`define DPSEL_TAP_PADR      4'h6
`define DPSEL_TAP_EX2DR     4'h7
`define DPSEL_TAP_UPDR      4'h8
`define DPSEL_TAP_SELIR     4'h9
`define DPSEL_TAP_CAPIR     4'hA
`define DPSEL_TAP_SHIR      4'hB
`define DPSEL_TAP_EX1IR     4'hC
`define DPSEL_TAP_PAIR      4'hD
`define DPSEL_TAP_EX2IR     4'hE
`define DPSEL_TAP_UPIR      4'hF
`endif

// ### design/dpsel_tap_tracker.v
`timescale 1ns/1ps
`default_nettype none
`include "dpsel_defs.vh"
// ----------------------------------------------------------------
// TAP state tracker, advances once per debug clock rising edge
// ----------------------------------------------------------------
module dpsel_tap_tracker (
    input  wire       sys_clk,
    input  wire       reset_n,
    input  wire       tapResetSync,
    input  wire       clkRise,
    input  wire       modeBit,
    output reg  [3:0] tapState_r
);
    reg [3:0] tapState_nxt;   // Next TAP state

    // Standard TAP transition table
    always @* begin
        case (tapState_r)
            `DPSEL_TAP_TLR:   tapState_nxt = modeBit ? `DPSEL_TAP_TLR   : `DPSEL_TAP_RTI;
            `DPSEL_TAP_RTI:   tapState_nxt = modeBit ? `DPSEL_TAP_SELDR : `DPSEL_TAP_RTI;
            `DPSEL_TAP_SELDR: tapState_nxt = modeBit ? `DPSEL_TAP_SELIR : `DPSEL_TAP_CAPDR;
            `DPSEL_TAP_CAPDR: tapState_nxt = modeBit ? `DPSEL_TAP_EX1DR : `DPSEL_TAP_SHDR;
            `DPSEL_TAP_SHDR:  tapState_nxt = modeBit ? `DPSEL_TAP_EX1DR : `DPSEL_TAP_SHDR;
            `DPSEL_TAP_EX1DR: tapState_nxt = modeBit ? `DPSEL_TAP_UPDR  : `DPSEL_TAP_PADR;
            `DPSEL_TAP_PADR:  tapState_nxt = modeBit ? `DPSEL_TAP_EX2DR : `DPSEL_TAP_PADR;
            `DPSEL_TAP_EX2DR: tapState_nxt = modeBit ? `DPSEL_TAP_UPDR  : `DPSEL_TAP_SHDR;
            `DPSEL_TAP_UPDR:  tapState_nxt = modeBit ? `DPSEL_TAP_SELDR : `DPSEL_TAP_RTI;
            `DPSEL_TAP_SELIR: tapState_nxt = modeBit ? `DPSEL_TAP_TLR   : `DPSEL_TAP_CAPIR;
            `DPSEL_TAP_CAPIR: tapState_nxt = modeBit ? `DPSEL_TAP_EX1IR : `DPSEL_TAP_SHIR;
            `DPSEL_TAP_SHIR:  tapState_nxt = modeBit ? `DPSEL_TAP_EX1IR : `DPSEL_TAP_SHIR;
            `DPSEL_TAP_EX1IR: tapState_nxt = modeBit ? `DPSEL_TAP_UPIR  : `DPSEL_TAP_PAIR;
            `DPSEL_TAP_PAIR:  tapState_nxt = modeBit ? `DPSEL_TAP_EX2IR : `DPSEL_TAP_PAIR;
            `DPSEL_TAP_EX2IR: tapState_nxt = modeBit ? `DPSEL_TAP_UPIR  : `DPSEL_TAP_SHIR;
            `DPSEL_TAP_UPIR:  tapState_nxt = modeBit ? `DPSEL_TAP_SELDR : `DPSEL_TAP_RTI;
            default:          tapState_nxt = `DPSEL_TAP_TLR;
        endcase
    end

    // State register; TAP reset pin forces reset state
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tapState_r <= `DPSEL_TAP_TLR;
        end else if (tapResetSync) begin
            tapState_r <= `DPSEL_TAP_TLR;
        end else if (clkRise) begin
            tapState_r <= tapState_nxt;
        end
    end
endmodule // dpsel_tap_tracker
`default_nettype wire

// ### design/dpsel_watcher.v
`timescale 1ns/1ps
`default_nettype none
`include "dpsel_defs.vh"
// Behaviour
// - Detect JTAG-to-wire pattern 0x79E7
// - JTAG detection only starting from reset state
// - Serial wire starts in line reset
// - Detect wire-to-JTAG pattern 0x3CE7
// - Wire detection only from line reset
// - Quiescent state ignores all pin stimulus except the TAP reset pin
// - Dormant support provided here
// - Quiescent entry from JTAG mode only
// - Wire-only variant starts quiescent
// - Track shift visited since capture
// - Clear counter on reset, select-IR, TAP_LOGIC_RESET_STATE
// - Zero-bit update increments, saturates seven
// - Lock on shift entry when nonzero
// - Quiescent on idle with locked six
// - After TAP_LOGIC_RESET_STATE, JTAG-to-wire detectable again
// - Powerup default is JTAG
// - Ignore further patterns until reset
module dpsel_watcher #(
    parameter WIRE_ONLY = 0          // 1: wire-only variant
) (
    input  wire debug_clock_pin,
    input  wire debug_io_mode_pin,
    input  wire tap_async_reset_n,
    input  wire sys_clk,
    input  wire reset_n,
    output reg  jtagSelected_r,
    output reg  wireSelected_r,
    output reg  quiescent_r,
    output reg  wireLineReset_r,
    output reg  tapLogicReset_r,
    output reg  [2:0] zeroScanCount_r,
    output reg  scanCounterLocked_r
);
    // ------------------------------------------------------------
    // Mode states, one-hot
    // ------------------------------------------------------------
    localparam [2:0] ST_JTAG  = 3'h1;   // JTAG selected
    localparam [2:0] ST_WIRE  = 3'h2;   // Serial wire selected
    localparam [2:0] ST_QUIET = 3'h4;   // Quiescent state
    reg        [2:0] mode_r;            // Current operating mode
    reg        [2:0] mode_nxt;          // Next operating mode

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg  [1:0] clkSync_r;     // Debug clock sampler
    reg  [1:0] ioSync_r;      // Mode pin sampler
    reg  [1:0] trstSync_r;    // TAP reset sampler, active low
    reg        clkPrev_r;     // Last synced clock level
    wire       clkRise;       // Debug clock rising edge
    wire       tapResetSync;  // TAP reset held

    // Two stages each; only second stage is read
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkSync_r  <= 2'h0;
            ioSync_r   <= 2'h3;
            trstSync_r <= 2'h0;
            clkPrev_r  <= 1'b0;
        end else begin
            clkSync_r  <= {clkSync_r[0], debug_clock_pin};
            ioSync_r   <= {ioSync_r[0], debug_io_mode_pin};
            trstSync_r <= {trstSync_r[0], tap_async_reset_n};
            clkPrev_r  <= clkSync_r[1];
        end
    end

    assign clkRise      = clkSync_r[1] & ~clkPrev_r;
    assign tapResetSync = ~trstSync_r[1];

    // ------------------------------------------------------------
    // TAP tracker
    // ------------------------------------------------------------
    wire [3:0] tapState;      // Tracked TAP state
    reg  [3:0] tapPrev_r;     // Previous TAP state
    wire       tapEnter;      // TAP entered a state, self loops included
    reg        enterPulse_r;  // Edge processed last cycle
    wire       tapClkRise;    // Debug clock edge seen by the TAP

    // TAP only follows the pin while JTAG is selected
    assign tapClkRise = clkRise & (mode_r == ST_JTAG);

    dpsel_tap_tracker u_tap (
        .sys_clk      (sys_clk),
        .reset_n      (reset_n),
        .tapResetSync (tapResetSync),
        .clkRise      (tapClkRise),
        .modeBit      (ioSync_r[1]),
        .tapState_r   (tapState)
    );

    // Track entries into states, one cycle after move
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tapPrev_r <= `DPSEL_TAP_TLR;
        end else begin
            tapPrev_r <= tapState;
        end
    end

    // A self loop, such as idle held, still counts as an entry
    assign tapEnter = (tapPrev_r != tapState) | enterPulse_r;

    // Pulse marking a clocked move, also for self loops
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enterPulse_r <= 1'b0;
        end else begin
            enterPulse_r <= tapClkRise;
        end
    end

    // ------------------------------------------------------------
    // Pattern shifter and high-run counter
    // ------------------------------------------------------------
    reg  [15:0] shift_r;      // Last sixteen mode bits
    reg  [5:0]  highRun_r;    // Consecutive high bits, saturating
    reg  [4:0]  patCount_r;   // Bits since detection start
    reg         armed_r;      // Detection allowed
    wire        bitIn;        // Sampled mode bit

    assign bitIn = ioSync_r[1];

    // Shift on each debug clock rising edge
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_r    <= 16'hFFFF;
            highRun_r  <= 6'h00;
            patCount_r <= 5'h00;
        end else if (clkRise) begin
            shift_r <= {shift_r[14:0], bitIn};
            // High run, saturating at its ceiling
            if (bitIn) begin
                if (highRun_r != 6'h3F) begin
                    highRun_r <= highRun_r + 6'h01;
                end
            end else begin
                highRun_r <= 6'h00;
            end
            // Bit count: a fifth high realigns, the TAP is then in reset
            // and no select pattern holds five highs in a row
            if (bitIn && (highRun_r >= `DPSEL_REALIGN_RUN)) begin
                patCount_r <= 5'h00;
            end else if (patCount_r == 5'h00) begin
                if (!bitIn) begin
                    patCount_r <= 5'h01;                         // First low opens a pattern
                end
            end else if (patCount_r != 5'h1F) begin
                patCount_r <= patCount_r + 5'h01;
            end else if (bitIn) begin
                patCount_r <= 5'h00;                             // Stale run ends on a high
            end
        end
    end

    // Line reset seen on this edge
    wire lineResetHit;
    assign lineResetHit = clkRise & bitIn
                        & (highRun_r >= (`DPSEL_LINE_RESET_MIN - 1));

    // Complete pattern on this edge
    wire [15:0] shiftNow;
    wire        patDone;
    assign shiftNow = {shift_r[14:0], bitIn};
    assign patDone  = clkRise & (patCount_r == (`DPSEL_PAT_BITS - 1));

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    reg       armed_nxt;      // Next detection allowance
    reg       lineReset_nxt;  // Next line-reset status
    wire      enterQuiet;     // Dormant entry condition

    always @* begin
        mode_nxt      = mode_r;
        armed_nxt     = armed_r;
        lineReset_nxt = wireLineReset_r;
        case (mode_r)
            ST_JTAG: begin
                if (tapState == `DPSEL_TAP_TLR && patCount_r == 5'h00) begin
                    armed_nxt = 1'b1;
                end
                if (patDone && armed_r && shiftNow == `DPSEL_J2S_PATTERN) begin
                    mode_nxt      = ST_WIRE;
                    armed_nxt     = 1'b0;
                    lineReset_nxt = 1'b1;
                end else if (enterQuiet) begin
                    mode_nxt  = ST_QUIET;
                    armed_nxt = 1'b0;
                end else if (patDone && tapState != `DPSEL_TAP_TLR) begin
                    armed_nxt = 1'b0;
                end
            end
            ST_WIRE: begin
                if (lineResetHit) begin
                    lineReset_nxt = 1'b1;
                    armed_nxt     = 1'b1;
                end else if (clkRise && !bitIn && patCount_r > 5'h01) begin
                    lineReset_nxt = 1'b0;
                end
                if (patDone && armed_r && shiftNow == `DPSEL_S2J_PATTERN) begin
                    mode_nxt      = ST_JTAG;
                    armed_nxt     = 1'b0;
                    lineReset_nxt = 1'b0;
                end else if (patDone) begin
                    armed_nxt = 1'b0;
                end
            end
            ST_QUIET: begin
                mode_nxt = ST_QUIET;
            end
            default: begin
                mode_nxt = ST_JTAG;
            end
        endcase
    end

    // Mode registers; powerup gives JTAG or quiescent
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r          <= (WIRE_ONLY != 0) ? ST_QUIET : ST_JTAG;
            armed_r         <= 1'b0;
            wireLineReset_r <= 1'b0;
        end else begin
            mode_r          <= mode_nxt;
            armed_r         <= armed_nxt;
            wireLineReset_r <= lineReset_nxt;
        end
    end

    // ------------------------------------------------------------
    // Zero-bit scan detector
    // ------------------------------------------------------------
    reg shiftVisited_r;       // Shift entered since capture

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftVisited_r      <= 1'b0;
            zeroScanCount_r     <= 3'h0;
            scanCounterLocked_r <= 1'b0;
        end else if (tapEnter) begin
            case (tapState)
                `DPSEL_TAP_CAPDR: begin
                    shiftVisited_r <= 1'b0;
                end
                `DPSEL_TAP_SHDR: begin
                    shiftVisited_r <= 1'b1;
                    if (zeroScanCount_r != 3'h0) begin
                        scanCounterLocked_r <= 1'b1;
                    end
                end
                `DPSEL_TAP_UPDR: begin
                    if (!scanCounterLocked_r && !shiftVisited_r
                        && zeroScanCount_r < `DPSEL_ZBS_MAX) begin
                        zeroScanCount_r <= zeroScanCount_r + 3'h1;
                    end
                end
                `DPSEL_TAP_SELIR, `DPSEL_TAP_TLR: begin
                    zeroScanCount_r     <= 3'h0;
                    scanCounterLocked_r <= 1'b0;
                end
                default: begin
                    shiftVisited_r <= shiftVisited_r;
                end
            endcase
        end
    end

    // Only a locked six enters; other locked counts keep the mode
    assign enterQuiet = tapEnter && (tapState == `DPSEL_TAP_RTI)
                      && scanCounterLocked_r
                      && (zeroScanCount_r == `DPSEL_ZBS_ENTRY);

    // ------------------------------------------------------------
    // Status outputs, registered
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            jtagSelected_r  <= 1'b0;
            wireSelected_r  <= 1'b0;
            quiescent_r     <= 1'b0;
            tapLogicReset_r <= 1'b1;
        end else begin
            jtagSelected_r  <= (mode_r == ST_JTAG);
            wireSelected_r  <= (mode_r == ST_WIRE);
            quiescent_r     <= (mode_r == ST_QUIET);
            tapLogicReset_r <= (tapState == `DPSEL_TAP_TLR);
        end
    end
endmodule // dpsel_watcher
`default_nettype wire

// ### dv/dpsel_probe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Probe model: debug clock and mode pin
// ----------------------------------------
module dpsel_probe_model (
    input  wire logic sys_clk,
    output var  logic dbgClk,
    output var  logic modeOut
);
    initial begin
        dbgClk  = 1'b0;                      // Clock parked low between frames
        modeOut = 1'b1;                      // Mode pin idles high
    end

    // One bit, 320 ns period, mode set while clock is low
    task automatic bitOut(input logic b);
        @(posedge sys_clk);
        modeOut <= b;
        repeat (3) @(posedge sys_clk);
        dbgClk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        dbgClk <= 1'b0;
    endtask

    // One low clock, walks the TAP from reset to idle
    task automatic parkIdle;
        bitOut(1'b0);
    endtask

    // High run, puts either engine in reset
    task automatic highs(input int n);
        repeat (n) bitOut(1'b1);
    endtask

    // Sequence MSB first, no extra lows added
    task automatic word(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) bitOut(v[i]);
    endtask
endmodule // dpsel_probe_model
`default_nettype wire

// ### dv/dpsel_watcher_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Watcher checker, port level only
// ----------------------------------------
module dpsel_watcher_assertions #(
    parameter WIRE_ONLY = 0                  // Variant flag, as on design
) (
    input wire logic       debug_clock_pin,
    input wire logic       debug_io_mode_pin,
    input wire logic       tap_async_reset_n,
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       jtagSelected_r,
    input wire logic       wireSelected_r,
    input wire logic       quiescent_r,
    input wire logic       wireLineReset_r,
    input wire logic       tapLogicReset_r,
    input wire logic [2:0] zeroScanCount_r,
    input wire logic       scanCounterLocked_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_modes_exclusive: assert property (!(jtagSelected_r && wireSelected_r))
        else $error("both protocols selected");
    a_wire_starts_reset: assert property ($rose(wireSelected_r) |-> wireLineReset_r)
        else $error("serial wire selected outside line reset");
    a_count_step: assert property (zeroScanCount_r != $past(zeroScanCount_r) |->
        zeroScanCount_r == $past(zeroScanCount_r) + 3'h1 || zeroScanCount_r == 3'h0)
        else $error("scan count jumped");
    a_lock_freeze: assert property (scanCounterLocked_r && $past(scanCounterLocked_r)
        |-> $stable(zeroScanCount_r))
        else $error("locked count changed");
    a_lock_nonzero: assert property ($rose(scanCounterLocked_r) |-> zeroScanCount_r != 3'h0)
        else $error("lock taken on zero count");
    a_tlr_clears: assert property (tapLogicReset_r |-> ##[0:4]
        (zeroScanCount_r == 3'h0 && !scanCounterLocked_r))
        else $error("count not cleared in reset state");
    a_quiet_entry: assert property ((WIRE_ONLY == 0) && $rose(quiescent_r) |->
        scanCounterLocked_r && zeroScanCount_r == 3'h6)
        else $error("quiescent without locked six");
    a_quiet_sticky: assert property (quiescent_r |=> quiescent_r)
        else $error("quiescent state left");
    a_quiet_frozen: assert property (quiescent_r |=>
        $stable({jtagSelected_r, wireSelected_r, zeroScanCount_r}))
        else $error("state moved while quiescent");

    // Main scenarios reached
    c_wire: cover property ($rose(wireSelected_r));
    c_quiet: cover property ($rose(quiescent_r));
    c_sat: cover property (zeroScanCount_r == 3'h7);
    c_lock: cover property ($rose(scanCounterLocked_r));
endmodule // dpsel_watcher_assertions

bind dpsel_watcher dpsel_watcher_assertions #(.WIRE_ONLY(WIRE_ONLY)) chkInst (
    .debug_clock_pin(debug_clock_pin), .debug_io_mode_pin(debug_io_mode_pin),
    .tap_async_reset_n(tap_async_reset_n), .sys_clk(sys_clk), .reset_n(reset_n),
    .jtagSelected_r(jtagSelected_r), .wireSelected_r(wireSelected_r),
    .quiescent_r(quiescent_r), .wireLineReset_r(wireLineReset_r),
    .tapLogicReset_r(tapLogicReset_r), .zeroScanCount_r(zeroScanCount_r),
    .scanCounterLocked_r(scanCounterLocked_r)
);
`default_nettype wire

// ### dv/dpsel_watcher_test.sv
`timescale 1ns/1ps
`default_nettype none
module dpsel_watcher_test;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic            sys_clk;                // 25 MHz clock
    logic            reset_n;                // Block reset
    logic            tapRst_n;               // TAP reset pin
    wire logic       dbgClk;                 // Probe clock
    wire logic       modeBit;                // Probe mode pin
    wire logic       jtagSel, wireSel, quiet, lineRst, tapTlr, locked;
    wire logic [2:0] zbCount;                // Zero-bit scan count
    wire logic       jtagW, wireW, quietW;   // Wire-only variant status
    wire logic [6:0] stat;                   // Packed status view
    int              miscompares;
    int              check_count;
    int              cycles;                 // Timeout counter

    assign stat = {jtagSel, wireSel, quiet, zbCount, locked};

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    dpsel_probe_model probe (.sys_clk(sys_clk), .dbgClk(dbgClk), .modeOut(modeBit));

    dpsel_watcher uut (
        .debug_clock_pin(dbgClk), .debug_io_mode_pin(modeBit),
        .tap_async_reset_n(tapRst_n), .sys_clk(sys_clk), .reset_n(reset_n),
        .jtagSelected_r(jtagSel), .wireSelected_r(wireSel), .quiescent_r(quiet),
        .wireLineReset_r(lineRst), .tapLogicReset_r(tapTlr),
        .zeroScanCount_r(zbCount), .scanCounterLocked_r(locked)
    );

    // Wire-only variant on the same pins, powers up quiescent
    dpsel_watcher #(.WIRE_ONLY(1)) uutWire (
        .debug_clock_pin(dbgClk), .debug_io_mode_pin(modeBit),
        .tap_async_reset_n(tapRst_n), .sys_clk(sys_clk), .reset_n(reset_n),
        .jtagSelected_r(jtagW), .wireSelected_r(wireW), .quiescent_r(quietW),
        .wireLineReset_r(), .tapLogicReset_r(),
        .zeroScanCount_r(), .scanCounterLocked_r()
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Lets the synchroniser and status updates land
    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask

    task automatic close_out;
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        settle;
        chk(stat, 7'h40);
        chk({jtagW, wireW, quietW}, 3'h1);
        chk(tapTlr, 1'h1);
    endtask

    // One zero-bit scan, lock in shift, idle with count one
    task automatic t_lock;
        probe.parkIdle;
        probe.word(4'hB, 4);
        settle;
        chk(stat, 7'h42);
        probe.word(6'h26, 6);
        settle;
        chk(stat, 7'h43);
        probe.word(2'h3, 2);
        settle;
        chk(stat, 7'h40);
        probe.word(2'h2, 2);
    endtask

    // Eight zero-bit scans, pin reset, five highs realign, then select
    task automatic t_sat;
        repeat (8) probe.word(4'hB, 4);
        settle;
        chk(stat, 7'h4E);
        @(posedge sys_clk);
        tapRst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        tapRst_n <= 1'b1;
        settle;
        chk(stat, 7'h40);
        chk(tapTlr, 1'h1);
        probe.highs(5);
        probe.word(16'h79E7, 16);
        probe.highs(50);
        settle;
        chk(stat, 7'h20);
        chk(lineRst, 1'h1);
    endtask

    // Back to JTAG; no port registers here to reprogram
    task automatic t_s2j;
        probe.highs(50);
        probe.word(16'h3CE7, 16);
        probe.highs(5);
        settle;
        chk(stat, 7'h40);
        chk(tapTlr, 1'h1);
    endtask

    // Counter aligned by 31 lows and a high, TAP left outside reset
    task automatic t_notlr;
        probe.word(32'h00000001, 32);
        probe.word(16'h79E7, 16);
        probe.highs(50);
        settle;
        chk(stat, 7'h40);
    endtask

    // Five highs reset the TAP, six zero-bit scans lock, idle enters quiescent
    task automatic t_dormant;
        probe.highs(5);
        probe.word(31'h2EEEEEE6, 31);
        settle;
        chk(stat, 7'h1D);
        probe.highs(50);
        probe.word(16'h79E7, 16);
        probe.highs(50);
        settle;
        chk(stat, 7'h1D);
        chk({jtagW, wireW, quietW}, 3'h1);
    endtask

    // ----------------------------------------
    // Main sequence and timeout
    // ----------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            close_out;
        end
    end

    initial begin
        reset_n = 1'b0;
        tapRst_n = 1'b1;
        miscompares = 0;
        check_count = 0;
        cycles = 0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset;
        t_lock;
        t_sat;
        t_s2j;
        t_notlr;
        t_dormant;
        close_out;
    end
endmodule // dpsel_watcher_test
`default_nettype wire
